// ---- hdl/swr_supervisor.sv ----
`include "swr_regs.svh"
module swr_supervisor #(
   parameter int unsigned WD_SHORT_TICKS = `SWR_WD_SHORT_TICKS,
   parameter int unsigned WD_LONG_TICKS  = `SWR_WD_LONG_TICKS,
   parameter int unsigned PULSE_TICKS    = `SWR_RST_PULSE_TICKS,
   parameter int unsigned DEB_TICKS      = `SWR_DEB_TICKS
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic manual_reset_n_input,
   input  wire logic watchdog_kick_input,
   input  wire logic wd_disable,
   input  wire logic wd_long_sel,
   output logic      reset_out_n,
   output logic      reset_out_oe_n,
   output logic      wd_expired
);
   // =====================================================
   // Microsecond tick; one clock, slow rates as enables
   logic [`SWR_TICK_W-1:0] div_r;
   logic                   tick_r;
   wire                    div_end = div_r == `SWR_TICK_W'(`SWR_TICK_CYC - 1);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         div_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         div_r  <= div_end ? '0 : div_r + `SWR_TICK_W'(1);
         tick_r <= div_end;
      end
   end

   // =====================================================
   // Manual reset filtering
   logic mr_level;
   swr_debounce #(
      .DEB_TICKS (DEB_TICKS)
   ) u_mr_deb (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .tick      (tick_r),
      .pin_in    (manual_reset_n_input),
      .level_out (mr_level)
   );

   // =====================================================
   // Kick and control synchronisers
   logic wdi_s1_r, wdi_s2_r, wdi_s3_r;
   logic dis_s1_r, dis_s2_r, lsel_s1_r, lsel_s2_r;

   always_ff @(posedge clk) begin
      wdi_s1_r  <= watchdog_kick_input;
      wdi_s2_r  <= wdi_s1_r;
      wdi_s3_r  <= wdi_s2_r;
      dis_s1_r  <= wd_disable;
      dis_s2_r  <= dis_s1_r;
      lsel_s1_r <= wd_long_sel;
      lsel_s2_r <= lsel_s1_r;
   end

   wire kick_edge = wdi_s2_r ^ wdi_s3_r;

   // =====================================================
   // Watchdog counter
   swr_pkg::swr_state_t   state_r, state_nxt;
   logic [`SWR_CNT_W-1:0] wd_cnt_r, wd_cnt_nxt;
   logic [`SWR_CNT_W-1:0] pulse_cnt_r, pulse_cnt_nxt;

   wire [`SWR_CNT_W-1:0] wd_limit = lsel_s2_r ? `SWR_CNT_W'(WD_LONG_TICKS)
                                              : `SWR_CNT_W'(WD_SHORT_TICKS);
   wire in_reset   = state_r != swr_pkg::SWR_ST_IDLE;
   wire wd_clear   = kick_edge || in_reset || dis_s2_r;
   wire wd_fire    = !wd_clear && tick_r && (wd_cnt_r >= wd_limit - `SWR_CNT_W'(1));
   wire pulse_done = tick_r && (pulse_cnt_r >= `SWR_CNT_W'(PULSE_TICKS - 1));

   assign wd_cnt_nxt = wd_clear ? '0 : (tick_r ? wd_cnt_r + `SWR_CNT_W'(1) : wd_cnt_r);

   // =====================================================
   // Reset sequencer
   always_comb begin
      state_nxt     = state_r;
      pulse_cnt_nxt = pulse_cnt_r;
      case (state_r)
         swr_pkg::SWR_ST_IDLE: begin
            pulse_cnt_nxt = '0;
            if (!mr_level) begin
               state_nxt = swr_pkg::SWR_ST_HOLD;
            end else if (wd_fire) begin
               state_nxt = swr_pkg::SWR_ST_PULSE;
            end
         end
         swr_pkg::SWR_ST_HOLD: begin
            pulse_cnt_nxt = '0;
            if (mr_level) begin
               state_nxt = swr_pkg::SWR_ST_PULSE;
            end
         end
         swr_pkg::SWR_ST_PULSE: begin
            // Manual reset during the pulse returns to hold, and the full pulse restarts on release
            if (!mr_level) begin
               state_nxt = swr_pkg::SWR_ST_HOLD;
            end else if (pulse_done) begin
               state_nxt = swr_pkg::SWR_ST_IDLE;
            end else if (tick_r) begin
               pulse_cnt_nxt = pulse_cnt_r + `SWR_CNT_W'(1);
            end
         end
         default: begin
            state_nxt     = swr_pkg::SWR_ST_PULSE;
            pulse_cnt_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r     <= swr_pkg::SWR_ST_PULSE;
         wd_cnt_r    <= '0;
         pulse_cnt_r <= '0;
      end else begin
         state_r     <= state_nxt;
         wd_cnt_r    <= wd_cnt_nxt;
         pulse_cnt_r <= pulse_cnt_nxt;
      end
   end

   // =====================================================
   // Outputs; open drain, enable low while pulling low
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reset_out_n    <= 1'b0;
         reset_out_oe_n <= 1'b0;
         wd_expired     <= 1'b0;
      end else begin
         reset_out_n    <= state_nxt == swr_pkg::SWR_ST_IDLE;
         reset_out_oe_n <= state_nxt == swr_pkg::SWR_ST_IDLE;
         wd_expired     <= state_r == swr_pkg::SWR_ST_IDLE && state_nxt == swr_pkg::SWR_ST_PULSE;
      end
   end

   // =====================================================
   // Checks
   a_mr_holds_reset: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == swr_pkg::SWR_ST_HOLD) |=> !reset_out_n)
      else $error("Reset released while manual reset held");

   a_wd_fire_reset: assert property (@(posedge clk) disable iff (sys_rst)
      (wd_fire && mr_level) |=> (!reset_out_n && wd_expired))
      else $error("Watchdog expiry did not assert reset");

   a_edge_clears: assert property (@(posedge clk) disable iff (sys_rst)
      kick_edge |=> wd_cnt_r == '0)
      else $error("Kick edge did not clear watchdog count");

   a_reset_clears: assert property (@(posedge clk) disable iff (sys_rst)
      in_reset |=> wd_cnt_r == '0)
      else $error("Watchdog count ran during reset");

   a_disable_blocks: assert property (@(posedge clk) disable iff (sys_rst)
      (dis_s2_r && $past(dis_s2_r)) |-> !wd_expired)
      else $error("Disabled watchdog fired");

   a_limit_select: assert property (@(posedge clk) disable iff (sys_rst)
      wd_fire |-> (lsel_s2_r ? wd_cnt_r == `SWR_CNT_W'(WD_LONG_TICKS - 1)
                             : wd_cnt_r >= `SWR_CNT_W'(WD_SHORT_TICKS - 1)))
      else $error("Watchdog fired at wrong count");

   a_pulse_min: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(reset_out_n) |=> !reset_out_n [*8])
      else $error("Reset pulse too short");

   a_release_full: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(reset_out_n) |-> $past(pulse_cnt_r) == `SWR_CNT_W'(PULSE_TICKS - 1))
      else $error("Reset released before full pulse time");

   a_debounced_only: assert property (@(posedge clk) disable iff (sys_rst)
      $changed(mr_level) |-> $past(tick_r))
      else $error("Filtered manual reset moved off a tick");

   a_oe_follows: assert property (@(posedge clk) disable iff (sys_rst)
      reset_out_oe_n == reset_out_n)
      else $error("Pin enable does not follow reset level");

   a_mr_asserts: assert property (@(posedge clk) disable iff (sys_rst)
      !mr_level |=> !reset_out_n)
      else $error("Manual reset did not assert reset");

   a_idle_released: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == swr_pkg::SWR_ST_IDLE && mr_level && !wd_fire) |=> reset_out_n)
      else $error("Reset asserted without a trigger");

   a_expired_single: assert property (@(posedge clk) disable iff (sys_rst)
      wd_expired |=> !wd_expired)
      else $error("Expiry flag longer than one cycle");

   a_count_runs: assert property (@(posedge clk) disable iff (sys_rst)
      (tick_r && !wd_clear) |=> wd_cnt_r == $past(wd_cnt_r) + `SWR_CNT_W'(1))
      else $error("Watchdog count did not advance");

   a_disabled_zero: assert property (@(posedge clk) disable iff (sys_rst)
      dis_s2_r |=> wd_cnt_r == '0)
      else $error("Disabled watchdog kept counting");

   a_tick_spacing: assert property (@(posedge clk) disable iff (sys_rst)
      tick_r |=> !tick_r [*8])
      else $error("Time base ticks too close");

   // =====================================================
   // Check helper; saturates so a long manual hold cannot wrap
   logic [`SWR_CNT_W-1:0] low_ticks_r;
   wire                   low_ticks_full = &low_ticks_r;

   always_ff @(posedge clk) begin
      if (sys_rst || reset_out_n) begin
         low_ticks_r <= '0;
      end else if (tick_r && !low_ticks_full) begin
         low_ticks_r <= low_ticks_r + `SWR_CNT_W'(1);
      end
   end

   a_pulse_ticks: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(reset_out_n) |-> low_ticks_r >= `SWR_CNT_W'(PULSE_TICKS))
      else $error("Reset low for fewer ticks than the pulse time");
endmodule

// ---- pkg/swr_regs.svh ----
`ifndef SWR_REGS_SVH
`define SWR_REGS_SVH
// =====================================================
// Time base
`define SWR_CLK_HZ          125000000
`define SWR_TICK_US         1
`define SWR_TICK_CYC        ((`SWR_CLK_HZ / 1000000) * `SWR_TICK_US)
// =====================================================
// Timing in microsecond ticks
`define SWR_WD_SHORT_MS     200
`define SWR_WD_LONG_MS      1600
`define SWR_WD_SHORT_TICKS  (`SWR_WD_SHORT_MS * 1000)
`define SWR_WD_LONG_TICKS   (`SWR_WD_LONG_MS * 1000)
`define SWR_RST_PULSE_MS    200
`define SWR_RST_PULSE_TICKS (`SWR_RST_PULSE_MS * 1000)
`define SWR_DEB_US          20000
`define SWR_DEB_TICKS       (`SWR_DEB_US / `SWR_TICK_US)
`define SWR_CNT_W           21
`define SWR_TICK_W          7
`endif

// ---- pkg/swr_pkg.sv ----
package swr_pkg;
   typedef enum logic [1:0] {
      SWR_ST_IDLE  = 2'b00,
      SWR_ST_HOLD  = 2'b01,
      SWR_ST_PULSE = 2'b10
   } swr_state_t;
endpackage

// ---- hdl/swr_debounce.sv ----
`include "swr_regs.svh"
// =====================================================
// Pin synchroniser and stability filter
module swr_debounce #(
   parameter int unsigned DEB_TICKS = `SWR_DEB_TICKS
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic tick,
   input  wire logic pin_in,
   output logic      level_out
);
   logic                  sync1_r;
   logic                  sync2_r;
   logic [`SWR_CNT_W-1:0] stab_r;
   wire                   differs = sync2_r != level_out;
   wire                   settled = stab_r >= `SWR_CNT_W'(DEB_TICKS);

   always_ff @(posedge clk) begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
   end

   // Bounce restarts the stability count, so glitches never reach the output
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stab_r    <= '0;
         level_out <= 1'b1;
      end else if (!differs) begin
         stab_r <= '0;
      end else if (tick) begin
         if (settled) begin
            level_out <= sync2_r;
            stab_r    <= '0;
         end else begin
            stab_r <= stab_r + `SWR_CNT_W'(1);
         end
      end
   end

   a_deb_settled: assert property (@(posedge clk) disable iff (sys_rst)
      $changed(level_out) |-> ($past(tick && settled) && $past(sync2_r, 2) == level_out))
      else $error("Filtered level moved before it settled");
endmodule

// ---- sim/swr_host_model.sv ----
// ==========================================
// Host processor kicking the watchdog
module swr_host_model (
   input  wire logic        clk,
   input  wire logic        run,
   input  wire logic [15:0] half_cyc,
   output logic             kick
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_r;
   initial kick = 1'b0;
   initial cnt_r = 16'h0000;
   // Level freezes when stopped, so both stall levels get exercised
   always @(posedge clk) begin
      cnt_r <= (run && cnt_r < half_cyc) ? cnt_r + 16'h0001 : 16'h0000;
      if (run && cnt_r >= half_cyc) kick <= ~kick;
   end
endmodule

// ---- sim/tb_supervisor_watchdog_reset.sv ----
// ==========================================
// Bench for the supervisor
module tb_supervisor_watchdog_reset;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int T = 125, WS = 20, WL = 40, P = 10, D = 3, S = 16;
   logic        clk = 0, sys_rst = 1, mr_n = 1, dis = 0, lsel = 0, run = 0;
   logic [15:0] half = 16'h0100;
   wire         kick, rst_n, oe_n, expd;
   int          errors = 0, total_checks = 0, nexp = 0, n, h, lim;
   initial forever #4 clk = ~clk;
   swr_supervisor #(.WD_SHORT_TICKS(WS), .WD_LONG_TICKS(WL), .PULSE_TICKS(P), .DEB_TICKS(D)) swr_supervisor_i (
      .clk(clk), .sys_rst(sys_rst), .manual_reset_n_input(mr_n), .watchdog_kick_input(kick),
      .wd_disable(dis), .wd_long_sel(lsel), .reset_out_n(rst_n), .reset_out_oe_n(oe_n), .wd_expired(expd));
   swr_host_model swr_host_model_i (.clk(clk), .run(run), .half_cyc(half), .kick(kick));
   always @(negedge clk) if (expd === 1'b1) nexp++;
   // ==========================================
   // Checks and waits
   task automatic chk_rng(input int v, input int lo, input int hi, input string m);
      total_checks++;
      if (v < lo || v > hi) begin
         errors++;
         $display("mismatch at %0t: %s got %0d", $time, m, v);
      end
   endtask
   task automatic chk_bit(input logic v, input logic e, input string m);
      total_checks++;
      if (v !== e) begin
         errors++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   // One tick of phase plus sync and output delay
   function automatic int hi_of(input int ticks);
      return (ticks + 1) * T + S;
   endfunction
   // Bounded so a stuck output cannot hang the run
   task automatic wait_lvl(input logic e, output int c);
      c = 0;
      while (rst_n !== e && c < 60000) begin
         @(negedge clk);
         c++;
      end
   endtask
   task automatic stay_hi(input int cyc, output int lows);
      lows = 0;
      repeat (cyc) begin
         @(negedge clk);
         if (rst_n !== 1'b1) lows++;
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #(90000 * 8);
      errors++;
      test_done();
   end
   // ==========================================
   // Scenarios
   initial begin
      void'($urandom(81990));
      repeat (6) @(posedge clk);
      sys_rst <= 0;
      wait_lvl(1, n);
      chk_rng(n, (P - 1) * T, hi_of(P), "power-up pulse");
      $display("test start done");
      @(posedge clk) begin half <= 16'(200 + $urandom % 1000); run <= 1; end
      stay_hi(10000, n);
      chk_rng(n, 0, 0, "reset while kicked");
      $display("test kick done");
      for (int i = 0; i < 2; i++) begin
         @(posedge clk) lsel <= i[0];
         lim = i ? WL : WS;
         repeat (500) @(posedge clk);
         @(kick);
         @(posedge clk) run <= 0;
         wait_lvl(0, n);
         chk_rng(n, (lim - 1) * T, (lim + 1) * T + S, "expiry time");
         chk_bit(oe_n, 1'b0, "pin not driven");
         wait_lvl(1, n);
         chk_rng(n, (P - 1) * T, hi_of(P), "wd pulse");
         chk_bit(oe_n, 1'b1, "pin still driven");
         wait_lvl(0, n);
         chk_rng(n, (lim - 1) * T, (lim + 1) * T + S, "count after reset");
         wait_lvl(1, n);
         @(posedge clk) run <= 1;
         $display("test expiry %0d done", i);
      end
      chk_rng(nexp, 4, 4, "expiry pulses");
      @(posedge clk) begin dis <= 1; run <= 0; end
      stay_hi(2 * WL * T, n);
      chk_rng(n, 0, 0, "reset while disabled");
      @(posedge clk) run <= 1;
      repeat (10) @(posedge clk);
      dis <= 0;
      $display("test disable done");
      @(posedge clk) mr_n <= 0;
      repeat (T) @(posedge clk);
      mr_n <= 1;
      stay_hi(2000, n);
      chk_rng(n, 0, 0, "glitch reset");
      h = WS * T + $urandom % (WS * T);
      @(posedge clk) mr_n <= 0;
      wait_lvl(0, n);
      chk_rng(n, D * T, (D + 2) * T + S, "manual assert");
      repeat (h) @(posedge clk);
      mr_n <= 1;
      wait_lvl(1, n);
      chk_rng(n, (P + D - 1) * T, (P + D + 2) * T + S, "manual release");
      chk_rng(nexp, 4, 4, "no expiry on manual");
      $display("test manual done");
      test_done();
   end
endmodule
